// ==== hdl/cfg_pin_pkg.sv ====
// Shared constants, carrier types and decode helpers for the configuration pin controller
package cfg_pin_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int MODE_W = 4;
  localparam int DLY_W = 4;
  localparam int STATUS_BIT = 7;

  // ----------------------------------------------------------------
  // Configuration mode codes on the mode select pins
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_NONE = 4'h0;
  localparam logic [MODE_W-1:0] MODE_MASTER_PAR = 4'h4;
  localparam logic [MODE_W-1:0] MODE_ASYNC_PERIPH = 4'h5;
  localparam logic [MODE_W-1:0] MODE_SLAVE_PAR = 4'h7;
  localparam logic [MODE_W-1:0] MODE_PROC = 4'hB;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_POWER = 5'h01,
    ST_WAIT = 5'h02,
    ST_LOAD = 5'h04,
    ST_START = 5'h08,
    ST_USER = 5'h10
  } phase_t;

  // Host side configuration strobes and data
  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic rd_n;
    logic wr_n;
    logic [DATA_W-1:0] data;
  } host_bus_t;

  typedef struct packed {
    phase_t phase;
    logic [MODE_W-1:0] mode;
    logic init_prev;
    logic done;
    logic wr_prev;
    logic wr_pulse;
    logic [DATA_W-1:0] wbyte;
    logic stat_oe;
    logic stat_val;
    logic [ADDR_W-1:0] addr;
  } ctl_t;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic expired;
  } tmr_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam ctl_t CTL_RESET = '{ST_POWER, MODE_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00,
                                 1'b0, 1'b0, 18'h00000};
  localparam tmr_t TMR_RESET = '{4'h0, 1'b0};

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic uses_select(input logic [MODE_W-1:0] mode);
    return (mode == MODE_ASYNC_PERIPH) || (mode == MODE_SLAVE_PAR) || (mode == MODE_PROC);
  endfunction

  function automatic logic is_selected(input logic [MODE_W-1:0] mode, input host_bus_t bus);
    return uses_select(mode) && !bus.select_low_n && bus.select_high;
  endfunction

endpackage

// ==== hdl/release_timer.sv ====
// Start-up release timer: counts a loaded option delay after completion
`timescale 1ns/1ps
module release_timer #(
  parameter int W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [W-1:0] delay_i,
  output logic expired_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cfg_pin_pkg::tmr_t cur_ff;
  cfg_pin_pkg::tmr_t nxt_cur;

  // Counts up while started; sticks once the delay is reached
  always_comb begin
    nxt_cur = cur_ff;
    if (start_i && !cur_ff.expired) begin
      if (cur_ff.cnt == delay_i) begin
        nxt_cur.expired = 1'b1;
      end else begin
        nxt_cur.cnt = cur_ff.cnt + 4'h1;
      end
    end
  end

  // Registers the state copy
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur_ff <= cfg_pin_pkg::TMR_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign expired_o = cur_ff.expired;

endmodule

// ==== hdl/config_port_control_pins.sv ====
// Configuration-phase control pin controller: handshake, select, status and release
// Notes on behaviour
// - High flag is driven high from reset until configuration completes.
// - Low flag is driven low until configuration completes.
// - Hold line pulled low, open drain, during power settling and memory clearing.
// - External low on hold line keeps device waiting; no loading starts.
// - Selected only when low select is low and high select is high.
// - Async peripheral mode: read strobe low turns status bit line into output.
// - Status bit line high means ready, low means busy.
// - Read and write together: write wins and is performed.
// - Master parallel mode drives eighteen address lines to boot memory.
// - Other non-processor modes keep address lines floating with pull-ups.
// - After configuration, control pins are handed over to user I/O.
// - Done release and pin release are timed by two separate option groups.
// - Mode pins are latched on rising edge of the hold line.
// - Peripheral mode ready output tells host next byte may be written.
`timescale 1ns/1ps
module config_port_control_pins #(
  parameter int ADDR_W = 18,
  parameter int DLY_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic power_stable_i,
  input wire logic mem_clear_busy_i,
  input wire logic config_done_i,
  input wire logic load_ready_i,
  input wire logic [ADDR_W-1:0] boot_addr_i,
  input wire logic [DLY_W-1:0] done_delay_i,
  input wire logic [DLY_W-1:0] release_delay_i,
  input wire logic [3:0] mode_pins_i,
  input wire cfg_pin_pkg::host_bus_t host_i,
  input wire logic init_n_i,
  output logic init_n_o,
  output logic init_n_oe_o,
  output logic config_active_high_flag_o,
  output logic config_active_high_flag_oe_o,
  output logic config_active_low_flag_o,
  output logic config_active_low_flag_oe_o,
  output logic status_bit_line_o,
  output logic status_bit_line_oe_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  output logic addr_pullup_o,
  output logic ready_o,
  output logic byte_wr_o,
  output logic [7:0] byte_o,
  output logic [3:0] mode_o,
  output logic done_o,
  output logic done_oe_o,
  output logic user_io_en_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cfg_pin_pkg::ctl_t cur_ff;
  cfg_pin_pkg::ctl_t nxt_cur;
  logic done_rel;
  logic pins_rel;
  logic sel;
  logic in_load;

  assign in_load = (cur_ff.phase == cfg_pin_pkg::ST_LOAD);
  assign sel = cfg_pin_pkg::is_selected(cur_ff.mode, host_i);

  // Sequencer and host strobe handling
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.init_prev = init_n_i;
    nxt_cur.wr_prev = !host_i.wr_n;
    nxt_cur.wr_pulse = 1'b0;
    nxt_cur.stat_oe = 1'b0;
    nxt_cur.addr = boot_addr_i;
    unique case (cur_ff.phase)
      cfg_pin_pkg::ST_POWER: begin
        // Line stays low until supplies settle and memory is cleared
        if (power_stable_i && !mem_clear_busy_i) begin
          nxt_cur.phase = cfg_pin_pkg::ST_WAIT;
        end
      end
      cfg_pin_pkg::ST_WAIT: begin
        // Only a rising edge leaves; an external low keeps us here
        if (init_n_i && !cur_ff.init_prev) begin
          nxt_cur.mode = mode_pins_i;
          nxt_cur.phase = cfg_pin_pkg::ST_LOAD;
        end
      end
      cfg_pin_pkg::ST_LOAD: begin
        if (config_done_i) begin
          nxt_cur.done = 1'b1;
          nxt_cur.phase = cfg_pin_pkg::ST_START;
        end
      end
      cfg_pin_pkg::ST_START: begin
        if (pins_rel) begin
          nxt_cur.phase = cfg_pin_pkg::ST_USER;
        end
      end
      cfg_pin_pkg::ST_USER: begin
        nxt_cur.phase = cfg_pin_pkg::ST_USER;
      end
      default: begin
        nxt_cur = cfg_pin_pkg::CTL_RESET;
      end
    endcase
    // Write is checked first so a clash with read still performs the write
    if (in_load && sel) begin
      if (!host_i.wr_n) begin
        if (!cur_ff.wr_prev) begin
          nxt_cur.wr_pulse = 1'b1;
          nxt_cur.wbyte = host_i.data;
        end
      end else if (!host_i.rd_n && cur_ff.mode == cfg_pin_pkg::MODE_ASYNC_PERIPH) begin
        nxt_cur.stat_oe = 1'b1;
        nxt_cur.stat_val = load_ready_i;
      end
    end
  end

  // Registers the state copy
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur_ff <= cfg_pin_pkg::CTL_RESET;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // Start-up release timing
  // ----------------------------------------------------------------
  // Two timers so done and pin hand-over follow their own option groups
  release_timer #(.W(DLY_W)) u_done_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(cur_ff.done),
    .delay_i(done_delay_i),
    .expired_o(done_rel)
  );

  release_timer #(.W(DLY_W)) u_pins_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(cur_ff.done),
    .delay_i(release_delay_i),
    .expired_o(pins_rel)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign init_n_o = 1'b0;
  assign init_n_oe_o = (cur_ff.phase == cfg_pin_pkg::ST_POWER);

  // Both flags from one bit so they can never disagree for a cycle
  assign config_active_high_flag_o = !cur_ff.done;
  assign config_active_low_flag_o = cur_ff.done;
  assign config_active_high_flag_oe_o = !pins_rel;
  assign config_active_low_flag_oe_o = !pins_rel;

  // Status read-back on data bit line
  assign status_bit_line_o = cur_ff.stat_val;
  assign status_bit_line_oe_o = cur_ff.stat_oe && !pins_rel;

  // Boot memory addressing; pull-ups only where the pins are not ours
  assign addr_o = cur_ff.addr;
  assign addr_oe_o = in_load && (cur_ff.mode == cfg_pin_pkg::MODE_MASTER_PAR);
  assign addr_pullup_o = !pins_rel && !addr_oe_o && (cur_ff.mode != cfg_pin_pkg::MODE_PROC)
                         && (cur_ff.mode != cfg_pin_pkg::MODE_MASTER_PAR);

  assign ready_o = in_load && (cur_ff.mode == cfg_pin_pkg::MODE_ASYNC_PERIPH)
                   && load_ready_i;
  assign byte_wr_o = cur_ff.wr_pulse;
  assign byte_o = cur_ff.wbyte;
  assign mode_o = cur_ff.mode;

  // Done is open drain, held low until its own timer expires
  assign done_o = 1'b0;
  assign done_oe_o = !done_rel;
  assign user_io_en_o = pins_rel;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_status;
    in_load && sel && (cur_ff.mode == cfg_pin_pkg::MODE_ASYNC_PERIPH)
      && !host_i.rd_n && host_i.wr_n;
  endsequence

  sequence s_wr_clash;
    in_load && sel && !host_i.wr_n && !host_i.rd_n && !cur_ff.wr_prev;
  endsequence

  sequence s_init_rise;
    (cur_ff.phase == cfg_pin_pkg::ST_WAIT) && !init_n_i ##1 init_n_i;
  endsequence

  AST_HIGH_FLAG: assert property (
    !cur_ff.done |-> config_active_high_flag_o && config_active_high_flag_oe_o)
    else $error("high flag not driven high during configuration");

  AST_LOW_FLAG: assert property (
    !cur_ff.done |-> !config_active_low_flag_o && config_active_low_flag_oe_o)
    else $error("low flag not driven low during configuration");

  AST_INIT_HOLD: assert property (
    (cur_ff.phase == cfg_pin_pkg::ST_POWER) |-> init_n_oe_o && !init_n_o)
    else $error("hold line not pulled low while powering");

  AST_WAIT_HOLD: assert property (
    (cur_ff.phase == cfg_pin_pkg::ST_WAIT) && !init_n_i |=>
      (cur_ff.phase == cfg_pin_pkg::ST_WAIT))
    else $error("left wait state while hold line low");

  AST_SELECT: assert property (
    byte_wr_o |-> $past(!host_i.select_low_n && host_i.select_high))
    else $error("byte taken without both selects active");

  AST_STATUS_OE: assert property (
    s_rd_status |=> status_bit_line_oe_o)
    else $error("status line not driven on read");

  AST_STATUS_VAL: assert property (
    s_rd_status |=> status_bit_line_o == $past(load_ready_i))
    else $error("status value does not match ready");

  AST_WRITE_PRIO: assert property (
    s_wr_clash |=> byte_wr_o && !status_bit_line_oe_o && byte_o == $past(host_i.data))
    else $error("write did not win over read");

  AST_ADDR_DRIVE: assert property (
    in_load && (cur_ff.mode == cfg_pin_pkg::MODE_MASTER_PAR) |->
      addr_oe_o ##1 (addr_o == $past(boot_addr_i)))
    else $error("boot address not driven in master parallel mode");

  AST_ADDR_FLOAT: assert property (
    in_load && (cur_ff.mode != cfg_pin_pkg::MODE_MASTER_PAR)
      && (cur_ff.mode != cfg_pin_pkg::MODE_PROC) |-> !addr_oe_o && addr_pullup_o)
    else $error("address lines not floating with pull-ups");

  AST_HANDOVER: assert property (
    user_io_en_o |-> !config_active_high_flag_oe_o && !config_active_low_flag_oe_o
      && !status_bit_line_oe_o && !addr_oe_o && !addr_pullup_o && !init_n_oe_o)
    else $error("control pin still driven after hand-over");

  AST_DONE_TIMING: assert property (
    $rose(cur_ff.done) && (done_delay_i == 4'h0) |=> !done_oe_o)
    else $error("done not released after zero delay");

  AST_MODE_LATCH: assert property (
    s_init_rise |=> (mode_o == $past(mode_pins_i)) && in_load)
    else $error("mode not latched on hold line rise");

  AST_READY: assert property (
    ready_o |-> load_ready_i && in_load)
    else $error("ready shown while loader busy");

  AST_FLAGS_TOGETHER: assert property (
    config_active_high_flag_o != config_active_low_flag_o)
    else $error("flags changed on different edges");

endmodule

// ==== tb/host_model.sv ====
// Host processor model: selects, strobes, data and an external hold on the hold line
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_i,
  output cfg_pin_pkg::host_bus_t host_o,
  output logic hold_o
);
  // ---------------------------------------------
  // Bus driving
  // ---------------------------------------------
  // Idle: strobes high, deselected, hold asserted
  initial begin
    host_o = '{1'h1, 1'h0, 1'h1, 1'h1, 8'h5A};
    hold_o = 1'h1;
  end
  // The hold stays low until we let go; the device must wait for it
  task automatic set_hold(input logic h);
    @(posedge core_clk_i);
    hold_o <= h;
  endtask
  task automatic select(input logic lo_n, input logic hi);
    @(posedge core_clk_i);
    host_o.select_low_n <= lo_n;
    host_o.select_high <= hi;
  endtask
  // One byte per falling strobe; data is inverted on release so stale bytes never match
  task automatic write_byte(input logic [7:0] d, input logic with_rd);
    @(posedge core_clk_i);
    host_o.wr_n <= 1'h0;
    host_o.rd_n <= !with_rd;
    host_o.data <= d;
    @(posedge core_clk_i);
    host_o.wr_n <= 1'h1;
    host_o.rd_n <= 1'h1;
    host_o.data <= ~d;
  endtask
  task automatic read_strobe(input logic low);
    @(posedge core_clk_i);
    host_o.rd_n <= !low;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the configuration pin controller
`timescale 1ns/1ps
module tb;
  logic core_clk_i, rst_n_i, power_stable_i, mem_clear_busy_i, config_done_i, load_ready_i;
  logic [17:0] boot_addr_i;
  logic [3:0] mode_pins_i;
  logic init_n_i, init_n_o, init_n_oe_o, hold, hf, hf_oe, lf, lf_oe, st, st_oe;
  logic [17:0] addr_o;
  logic addr_oe_o, addr_pullup_o, ready_o, byte_wr_o, done_o, done_oe_o, user_io_en_o;
  logic [7:0] byte_o;
  logic [3:0] mode_o;
  cfg_pin_pkg::host_bus_t host_i;
  logic [3:0] done_dly, rel_dly;
  int err_total = 0;
  int tests_run = 0;
  // Hold line has a pull-up; either party may pull it low
  assign init_n_i = !(init_n_oe_o || hold);
  host_model host_model_inst (.core_clk_i(core_clk_i), .host_o(host_i), .hold_o(hold));
  config_port_control_pins config_port_control_pins_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .power_stable_i(power_stable_i), .mem_clear_busy_i(mem_clear_busy_i),
    .config_done_i(config_done_i), .load_ready_i(load_ready_i), .boot_addr_i(boot_addr_i),
    .done_delay_i(done_dly), .release_delay_i(rel_dly), .mode_pins_i(mode_pins_i),
    .host_i(host_i),
    .init_n_i(init_n_i), .init_n_o(init_n_o), .init_n_oe_o(init_n_oe_o),
    .config_active_high_flag_o(hf), .config_active_high_flag_oe_o(hf_oe),
    .config_active_low_flag_o(lf), .config_active_low_flag_oe_o(lf_oe),
    .status_bit_line_o(st), .status_bit_line_oe_o(st_oe), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .addr_pullup_o(addr_pullup_o), .ready_o(ready_o),
    .byte_wr_o(byte_wr_o), .byte_o(byte_o), .mode_o(mode_o), .done_o(done_o),
    .done_oe_o(done_oe_o), .user_io_en_o(user_io_en_o));
  // ---------------------------------------------
  // Clock, checking and closing
  // ---------------------------------------------
  initial begin
    core_clk_i = 1'h0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  // Reset, power settling, clearing, external hold, then loading in mode m
  task automatic bring_up(input logic [3:0] m, input int rst_len);
    @(posedge core_clk_i);
    rst_n_i <= 1'h0;
    mode_pins_i <= m;
    config_done_i <= 1'h0;
    mem_clear_busy_i <= 1'h1;
    host_model_inst.set_hold(1'h1);
    settle(rst_len);
    check("high flag", {hf, hf_oe, lf, lf_oe}, 32'hD);
    check("done hold", {done_oe_o, done_o, user_io_en_o}, 32'h4);
    @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    power_stable_i <= 1'h1;
    settle(4);
    check("hold pull while clearing", {init_n_oe_o, init_n_o}, 32'h2);
    @(posedge core_clk_i);
    mem_clear_busy_i <= 1'h0;
    settle(10);
    check("pull released", init_n_oe_o, 32'h0);
    check("ready while held", ready_o, 32'h0);
    host_model_inst.set_hold(1'h0);
    settle(3);
    check("mode latched", mode_o, m);
    check("ready in load", ready_o, m == cfg_pin_pkg::MODE_ASYNC_PERIPH);
    check("high flag loading", {hf, lf}, 32'h2);
    $display("test bring-up done");
  endtask
  // Only low select low with high select high lets a byte in
  task automatic t_select();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      host_model_inst.select(s[1], s[0]);
      host_model_inst.write_byte(8'hC3 ^ 8'(i), 1'h0);
      #1;
      check("byte strobe", byte_wr_o, s == 2'h1);
      if (s == 2'h1) check("byte", byte_o, 8'hC2);
    end
    $display("test select done");
  endtask
  // Status on the status bit line follows ready and busy while read is held
  task automatic t_status();
    // The select scan leaves the device deselected, so select it again first
    host_model_inst.select(1'h0, 1'h1);
    host_model_inst.read_strobe(1'h1);
    settle(1);
    check("status drive", {st_oe, st}, 32'h3);
    @(posedge core_clk_i);
    load_ready_i <= 1'h0;
    settle(1);
    check("status busy", {st_oe, st, ready_o}, 32'h4);
    host_model_inst.read_strobe(1'h0);
    settle(1);
    check("status off", st_oe, 32'h0);
    @(posedge core_clk_i);
    load_ready_i <= 1'h1;
    host_model_inst.write_byte(8'hA7, 1'h1);
    #1;
    check("clash write", {byte_wr_o, byte_o, st_oe}, 32'h34E);
    check("addr floating", {addr_oe_o, addr_pullup_o}, 32'h1);
    $display("test status done");
  endtask
  // Completion flips both flags together; done and pin release on separate delays
  // Counts are edges after the one that latches completion; release follows delay plus one
  task automatic t_release(input logic [3:0] dd, input logic [3:0] rd);
    int nd;
    int nu;
    nd = 0;
    nu = 0;
    @(posedge core_clk_i);
    done_dly <= dd;
    rel_dly <= rd;
    config_done_i <= 1'h1;
    #1;
    check("flags at completion", {hf, lf}, 32'h2);
    settle(1);
    check("flags after completion", {hf, lf}, 32'h1);
    check("done held at completion", {done_oe_o, done_o}, 32'h2);
    for (int n = 1; n < 24; n++) begin
      settle(1);
      if (nd == 0 && done_oe_o === 1'h0) nd = n;
      if (nu == 0 && user_io_en_o === 1'h1) nu = n;
    end
    check("done release cycle", nd, 32'(dd) + 32'd1);
    check("pin release cycle", nu, 32'(rd) + 32'd1);
    check("pins handed over", {hf_oe, lf_oe, st_oe, addr_oe_o, addr_pullup_o}, 32'h0);
    $display("test release done");
  endtask
  // Master parallel drives the boot address one cycle late
  task automatic t_addr();
    @(posedge core_clk_i);
    boot_addr_i <= 18'h2A5C3;
    settle(2);
    check("addr drive", {addr_oe_o, addr_o}, 32'h6A5C3);
    $display("test address done");
  endtask
  initial begin
    rst_n_i = 1'h0;
    power_stable_i = 1'h0;
    mem_clear_busy_i = 1'h1;
    config_done_i = 1'h0;
    load_ready_i = 1'h1;
    done_dly = 4'h3;
    rel_dly = 4'h7;
    boot_addr_i = 18'h0;
    mode_pins_i = cfg_pin_pkg::MODE_ASYNC_PERIPH;
    bring_up(cfg_pin_pkg::MODE_ASYNC_PERIPH, 20);
    t_select();
    t_status();
    t_release(4'h3, 4'h7);
    bring_up(cfg_pin_pkg::MODE_MASTER_PAR, 2);
    t_addr();
    bring_up(cfg_pin_pkg::MODE_SLAVE_PAR, 2);
    t_select();
    bring_up(cfg_pin_pkg::MODE_PROC, 2);
    t_select();
    // Zero done delay reaches the immediate-release corner of the done timer
    t_release(4'h0, 4'h2);
    report_and_stop();
  end
  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule
